// >>> rtl/rwgda_params.svh
// Constants for the RAM write guard and DMA arbiter
`ifndef RWGDA_PARAMS_SVH
`define RWGDA_PARAMS_SVH
`define RWGDA_RAM_BASE     32'h2000_0000
`define RWGDA_RAM_BYTES    32'h0000_3000
`define RWGDA_ALIAS_BASE   32'h2200_0000
`define RWGDA_ALIAS_END    32'h2400_0000
`define RWGDA_PALIAS_BASE  32'h4200_0000
`define RWGDA_PALIAS_END   32'h4400_0000
`define RWGDA_REG_BASE     32'h4000_0000
`define RWGDA_BLK_SHIFT    5
`define RWGDA_MAP_WORDS    12
`define RWGDA_WAIT_HI      2'h2
`define RWGDA_OFF_MAP0     12'h000
`define RWGDA_OFF_CTRL     12'h040
`define RWGDA_OFF_STAT     12'h044
`define RWGDA_OFF_MASK     12'h048
`define RWGDA_OFF_FADDR    12'h04C
`define RWGDA_OFF_FID      12'h050
`define RWGDA_OFF_MPUCFG   12'h054
`define RWGDA_OFF_MPUADR   12'h058
`define RWGDA_OFF_MPUTYP   12'h05C
`define RWGDA_CTRL_DMAEN   0
`define RWGDA_CTRL_HICLK   1
`define RWGDA_CTRL_MPUEN   2
`define RWGDA_ST_DMAF      0
`define RWGDA_ST_MPUF      1
`define RWGDA_ID_MAC       3'h1
`define RWGDA_ID_RX        3'h2
`define RWGDA_ID_TX        3'h3
`endif

// >>> rtl/rwgda_pkg.sv
// Types for the RAM write guard and DMA arbiter
package rwgda_pkg;
    typedef enum logic [1:0] {
        RWGDA_IDLE = 2'b00,
        RWGDA_WAIT = 2'b01,
        RWGDA_DONE = 2'b11
    } rwgda_state_t;
    typedef enum logic [1:0] {
        RWGDA_G_NONE = 2'b00,
        RWGDA_G_MAC  = 2'b01,
        RWGDA_G_RX   = 2'b10,
        RWGDA_G_TX   = 2'b11
    } rwgda_grant_t;
endpackage

// >>> rtl/rwgda_top.sv
// RAM front end with write-protection bitmap and DMA arbiter
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "rwgda_params.svh"
module rwgda_top
    import rwgda_pkg::*;
#(
    parameter int AW    = 12,
    parameter int WORDS = 3072
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic        hwrite,
    input  wire logic [1:0]  hsize,
    input  wire logic        hpriv,
    input  wire logic        htrans_valid,
    input  wire logic [31:0] hwdata,
    output logic             hready,
    output logic             hresp_err,
    output logic [31:0]      hrdata,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    input  wire logic [2:0]  dma_req,
    input  wire logic [2:0]  dma_we,
    input  wire logic [31:0] dma_addr_mac,
    input  wire logic [31:0] dma_addr_rx,
    input  wire logic [31:0] dma_addr_tx,
    input  wire logic [31:0] dma_wdata_mac,
    input  wire logic [31:0] dma_wdata_rx,
    output logic [2:0]       dma_gnt,
    output logic [31:0]      dma_rdata,
    output logic             irq
);
    localparam int NBLK = `RWGDA_MAP_WORDS * 32;

    logic [31:0]       mem [WORDS];
    logic [31:0]       map_r [`RWGDA_MAP_WORDS];
    logic [2:0]        ctrl_r;
    logic [1:0]        stat_r;
    logic [1:0]        mask_r;
    logic [31:0]       faddr_r;
    logic [2:0]        fid_r;
    logic [5:0]        mpucfg_r;
    logic [31:0]       mpuadr_r;
    logic [1:0]        mpu_typ_r;
    rwgda_state_t      st_r;
    logic [1:0]        wcnt_r;
    logic [31:0]       ha_r;
    logic              hw_r;
    logic [1:0]        hs_r;
    logic              hok_r;
    rwgda_grant_t      gnt;

    function automatic logic blk_prot(input logic [31:0] a);
        logic [31:0] off;
        logic [31:0] blk;
        off = a - `RWGDA_RAM_BASE;
        blk = off >> `RWGDA_BLK_SHIFT;
        if (blk >= 32'(NBLK))
            return 1'b0;
        return map_r[blk[8:5]][blk[4:0]];
    endfunction

    wire in_ram = haddr >= `RWGDA_RAM_BASE &&
                  haddr < `RWGDA_RAM_BASE + `RWGDA_RAM_BYTES;
    wire in_alias = (haddr >= `RWGDA_ALIAS_BASE &&
                     haddr < `RWGDA_ALIAS_END) ||
                    (haddr >= `RWGDA_PALIAS_BASE &&
                     haddr < `RWGDA_PALIAS_END);
    wire hw_deny = hwrite && !hpriv && blk_prot(haddr);
    wire hreq = hsel && htrans_valid && st_r == RWGDA_IDLE;
    wire hbad = in_alias || (hwrite && in_ram && hw_deny);

    // Host access sequencer: wait states only in high clock mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r   <= RWGDA_IDLE;
            wcnt_r <= 2'h0;
            ha_r   <= 32'h0000_0000;
            hw_r   <= 1'b0;
            hs_r   <= 2'h0;
            hok_r  <= 1'b0;
        end else begin
            unique case (st_r)
                RWGDA_IDLE: begin
                    if (hreq) begin
                        ha_r  <= haddr;
                        hw_r  <= hwrite;
                        hs_r  <= hsize;
                        hok_r <= in_ram && !hbad;
                        wcnt_r <= ctrl_r[`RWGDA_CTRL_HICLK] ?
                                  `RWGDA_WAIT_HI : 2'h0;
                        st_r  <= ctrl_r[`RWGDA_CTRL_HICLK] ?
                                 RWGDA_WAIT : RWGDA_DONE;
                    end
                end
                RWGDA_WAIT: begin
                    wcnt_r <= wcnt_r - 2'h1;
                    if (wcnt_r == 2'h1)
                        st_r <= RWGDA_DONE;
                end
                RWGDA_DONE: st_r <= RWGDA_IDLE;
                default:    st_r <= RWGDA_IDLE;
            endcase
        end
    end

    wire hdone = st_r == RWGDA_DONE;
    assign hready    = hdone;
    assign hresp_err = hdone && !hok_r;

    // DMA fixed-priority arbiter, one grant per cycle
    always_comb begin
        if (dma_req[0])
            gnt = RWGDA_G_MAC;
        else if (dma_req[1])
            gnt = RWGDA_G_RX;
        else if (dma_req[2])
            gnt = RWGDA_G_TX;
        else
            gnt = RWGDA_G_NONE;
    end
    assign dma_gnt = {gnt == RWGDA_G_TX, gnt == RWGDA_G_RX,
                      gnt == RWGDA_G_MAC};

    logic [31:0] da;
    logic [31:0] dwd;
    logic        dwe;
    logic [2:0]  did;
    always_comb begin
        da  = dma_addr_mac;
        dwd = dma_wdata_mac;
        dwe = 1'b0;
        did = 3'h0;
        unique case (gnt)
            RWGDA_G_MAC: begin
                dwe = dma_we[0];
                did = `RWGDA_ID_MAC;
            end
            RWGDA_G_RX: begin
                da  = dma_addr_rx;
                dwd = dma_wdata_rx;
                dwe = dma_we[1];
                did = `RWGDA_ID_RX;
            end
            RWGDA_G_TX: begin
                da  = dma_addr_tx;
                did = `RWGDA_ID_TX;                  // reads only
            end
            RWGDA_G_NONE: ;
        endcase
    end
    wire [AW-1:0] didx = AW'((da - `RWGDA_RAM_BASE) >> 2);
    wire d_fault = dwe && ctrl_r[`RWGDA_CTRL_DMAEN] &&
                   blk_prot(da);

    // RAM: host writes merged by size, DMA has its own port
    wire [AW-1:0] hidx = AW'((ha_r - `RWGDA_RAM_BASE) >> 2);
    logic [3:0] hbe;
    always_comb begin
        unique case (hs_r)
            2'h0:    hbe = 4'h1 << ha_r[1:0];
            2'h1:    hbe = ha_r[1] ? 4'hC : 4'h3;
            default: hbe = 4'hF;
        endcase
    end
    wire hwr = hdone && hok_r && hw_r;

    always_ff @(posedge pclk) begin
        if (hwr) begin
            for (int b = 0; b < 4; b++)
                if (hbe[b])
                    mem[hidx][b*8 +: 8] <= hwdata[b*8 +: 8];
        end
        if (dwe && !d_fault && gnt != RWGDA_G_NONE)
            mem[didx] <= dwd;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hrdata    <= 32'h0000_0000;
            dma_rdata <= 32'h0000_0000;
        end else begin
            if (hreq && in_ram && !hwrite)
                hrdata <= mem[AW'((haddr - `RWGDA_RAM_BASE) >> 2)];
            if (gnt != RWGDA_G_NONE && !dwe)
                dma_rdata <= mem[didx];
        end
    end

    // APB register slave, zero wait states
    wire        pacc = psel && penable;
    wire [11:0] poff = paddr[11:0];
    wire        pmap = poff < 12'(`RWGDA_MAP_WORDS * 4);
    wire        pin  = paddr[31:12] == `RWGDA_REG_BASE >> 12;
    wire        pknown = pin && (pmap ||
                         (poff >= `RWGDA_OFF_CTRL &&
                          poff <= `RWGDA_OFF_MPUTYP));
    wire        pwr = pacc && pwrite && pknown && pstrb == 4'hF;
    assign pready  = 1'b1;
    assign pslverr = pacc && !pknown;

    genvar gi;
    generate
        for (gi = 0; gi < `RWGDA_MAP_WORDS; gi++) begin : g_map
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    map_r[gi] <= 32'h0000_0000;
                else if (pwr && pmap && poff[5:2] == 4'(gi))
                    map_r[gi] <= pwdata;
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r   <= 3'h0;
            mask_r   <= 2'h0;
            mpucfg_r <= 6'h00;
        end else if (pwr) begin
            if (poff == `RWGDA_OFF_CTRL)
                ctrl_r <= pwdata[2:0];
            if (poff == `RWGDA_OFF_MASK)
                mask_r <= pwdata[1:0];
            if (poff == `RWGDA_OFF_MPUCFG)
                mpucfg_r <= pwdata[5:0];
        end
    end

    // Fault capture; a new fault wins over a same-cycle clear
    wire mpu_ev = hbad && hreq && ctrl_r[`RWGDA_CTRL_MPUEN];
    wire [1:0] clr = (pwr && poff == `RWGDA_OFF_STAT) ?
                     pwdata[1:0] : 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r    <= 2'h0;
            faddr_r   <= 32'h0000_0000;
            fid_r     <= 3'h0;
            mpuadr_r  <= 32'h0000_0000;
            mpu_typ_r <= 2'h0;
        end else begin
            stat_r[`RWGDA_ST_DMAF] <= d_fault ||
                (stat_r[`RWGDA_ST_DMAF] && !clr[0]);
            stat_r[`RWGDA_ST_MPUF] <= mpu_ev ||
                (stat_r[`RWGDA_ST_MPUF] && !clr[1]);
            if (d_fault) begin
                faddr_r <= da;
                fid_r   <= did;
            end
            if (mpu_ev) begin
                mpuadr_r  <= haddr;
                mpu_typ_r <= {hpriv, hwrite};
            end
        end
    end
    assign irq = |(stat_r & mask_r);

    always_comb begin
        prdata = 32'h0000_0000;
        if (pacc && pknown && !pwrite) begin
            if (pmap)
                prdata = map_r[poff[5:2]];
            else unique case (poff)
                `RWGDA_OFF_CTRL:   prdata = {29'h0, ctrl_r};
                `RWGDA_OFF_STAT:   prdata = {30'h0, stat_r};
                `RWGDA_OFF_MASK:   prdata = {30'h0, mask_r};
                `RWGDA_OFF_FADDR:  prdata = faddr_r;
                `RWGDA_OFF_FID:    prdata = {29'h0, fid_r};
                `RWGDA_OFF_MPUCFG: prdata = {26'h0, mpucfg_r};
                `RWGDA_OFF_MPUADR: prdata = mpuadr_r;
                `RWGDA_OFF_MPUTYP: prdata = {30'h0, mpu_typ_r};
                default:           prdata = 32'h0000_0000;
            endcase
        end
    end

    property p_prio;
        @(posedge pclk) disable iff (!presetn)
        (dma_req[0] |-> dma_gnt == 3'b001) and
        (!dma_req[0] && dma_req[1] |-> dma_gnt == 3'b010);
    endproperty
    a_prio: assert property (p_prio)
        else $error("DMA priority broken");

    property p_one;
        @(posedge pclk) disable iff (!presetn) $onehot0(dma_gnt);
    endproperty
    a_one: assert property (p_one)
        else $error("more than one DMA grant");

    property p_wait;
        @(posedge pclk) disable iff (!presetn)
        hreq && ctrl_r[`RWGDA_CTRL_HICLK] |-> !hready ##1 !hready
            ##1 !hready ##1 hready;
    endproperty
    a_wait: assert property (p_wait)
        else $error("high clock wait count wrong");

    property p_zw;
        @(posedge pclk) disable iff (!presetn)
        hreq && !ctrl_r[`RWGDA_CTRL_HICLK] |=> hready;
    endproperty
    a_zw: assert property (p_zw)
        else $error("zero wait access late");

    property p_deny;
        @(posedge pclk) disable iff (!presetn)
        hreq && in_ram && hwrite && !hpriv && blk_prot(haddr)
        |-> ##[1:3] hresp_err;
    endproperty
    a_deny: assert property (p_deny)
        else $error("protected user write not refused");

    property p_priv;
        @(posedge pclk) disable iff (!presetn)
        hreq && in_ram && (hpriv || !hwrite) |-> ##[1:3] (hready
            && !hresp_err);
    endproperty
    a_priv: assert property (p_priv)
        else $error("allowed access refused");

    property p_dmaf;
        @(posedge pclk) disable iff (!presetn)
        d_fault |=> stat_r[0] && faddr_r == $past(da)
            && fid_r != `RWGDA_ID_TX;
    endproperty
    a_dmaf: assert property (p_dmaf)
        else $error("DMA fault not captured");

    property p_dis;
        @(posedge pclk) disable iff (!presetn)
        !ctrl_r[`RWGDA_CTRL_DMAEN] && !stat_r[0] |=> !stat_r[0];
    endproperty
    a_dis: assert property (p_dis)
        else $error("DMA fault while check disabled");

    property p_alias;
        @(posedge pclk) disable iff (!presetn)
        hreq && in_alias |-> ##[1:3] hresp_err;
    endproperty
    a_alias: assert property (p_alias)
        else $error("alias access not faulted");
endmodule

// >>> tb/rwgda_dma_model.sv
// Peripheral DMA requester model for the RAM arbiter port
`timescale 1ns/1ns
module rwgda_dma_model (
    input  wire logic        pclk,
    input  wire logic [2:0]  dma_gnt,
    input  wire logic [31:0] dma_rdata,
    output logic [2:0]       dma_req,
    output logic [2:0]       dma_we,
    output logic [31:0]      addr_mac,
    output logic [31:0]      addr_rx,
    output logic [31:0]      addr_tx,
    output logic [31:0]      wdata_mac,
    output logic [31:0]      wdata_rx
);
    logic [31:0] a_r [3];
    logic [31:0] d_r [3];
    int          gnt_log [$];
    int          multi;
    assign addr_mac  = a_r[0];
    assign addr_rx   = a_r[1];
    assign addr_tx   = a_r[2];
    assign wdata_mac = d_r[0];
    assign wdata_rx  = d_r[1];
    initial begin
        dma_req = 3'h0;
        dma_we  = 3'h0;
        multi   = 0;
        for (int i = 0; i < 3; i++) begin
            a_r[i] = 32'h5A5A_5A5A;
            d_r[i] = 32'hA5A5_A5A5;
        end
    end
    always @(negedge pclk) begin
        if ($countones(dma_gnt) > 1)
            multi++;
    end
    // Channels run concurrently, so receive and transmit may pend together
    task automatic issue(input int ch, input logic w, input logic [31:0] a,
                         input logic [31:0] d, output logic [31:0] rd);
        int i;
        @(posedge pclk);
        dma_req[ch] <= 1'b1;
        dma_we[ch]  <= w;
        a_r[ch]     <= a;
        d_r[ch]     <= d;
        // Grant is taken at the rising edge that also performs the access
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (dma_gnt[ch] === 1'b1)
                break;
        end
        gnt_log.push_back(ch);
        // Released lines show the inverse so stale values cannot pass
        dma_req[ch] <= 1'b0;
        a_r[ch]     <= ~a;
        d_r[ch]     <= ~d;
        @(posedge pclk);
        rd = dma_rdata;
    endtask
endmodule

// >>> tb/rwgda_top_tb.sv
// Self-checking bench for the RAM write guard and DMA arbiter
`timescale 1ns/1ns
`include "rwgda_params.svh"
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); end end
module rwgda_top_tb;
    localparam logic [31:0] RB = `RWGDA_REG_BASE;
    localparam logic [31:0] RM = `RWGDA_RAM_BASE;
    logic        pclk, presetn, hsel, hwrite, hpriv, htrans_valid;
    logic [1:0]  hsize;
    logic [31:0] haddr, hwdata, paddr, pwdata, rd, dmar, al [4];
    logic        psel, penable, pwrite, e;
    logic [3:0]  pstrb;
    wire         hready, hresp_err, pready, pslverr, irq;
    wire  [31:0] hrdata, prdata, dma_rdata, am, ar, at, wm, wr;
    wire  [2:0]  dma_req, dma_we, dma_gnt;
    int          n_fail, cmp_count, lat;
    rwgda_top dut (.pclk(pclk), .presetn(presetn), .hsel(hsel),
        .haddr(haddr), .hwrite(hwrite), .hsize(hsize), .hpriv(hpriv),
        .htrans_valid(htrans_valid), .hwdata(hwdata), .hready(hready),
        .hresp_err(hresp_err), .hrdata(hrdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .dma_req(dma_req), .dma_we(dma_we), .dma_addr_mac(am),
        .dma_addr_rx(ar), .dma_addr_tx(at), .dma_wdata_mac(wm),
        .dma_wdata_rx(wr), .dma_gnt(dma_gnt), .dma_rdata(dma_rdata),
        .irq(irq));
    rwgda_dma_model u_dma (.pclk(pclk), .dma_gnt(dma_gnt),
        .dma_rdata(dma_rdata), .dma_req(dma_req), .dma_we(dma_we),
        .addr_mac(am), .addr_rx(ar), .addr_tx(at), .wdata_mac(wm),
        .wdata_rx(wr));
    always #5 pclk = ~pclk;
    task automatic apb(input logic w, input logic [11:0] off,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= RB + {20'h0_0000, off};
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Let the write settle before callers look at flags or irq
        @(negedge pclk);
    endtask
    task automatic bc(input logic [11:0] off, input logic [31:0] x);
        apb(1'b0, off, 32'h0000_0000);
        `CHK(e, 1'b0)
        `CHK(rd, x)
    endtask
    // Naturally aligned requests are kept to here, as the bus master must
    task automatic ahb(input logic w, input logic p, input logic [1:0] sz,
                       input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        {hsel, htrans_valid, hwrite, hpriv} <= {2'b11, w, p};
        hsize  <= sz;
        haddr  <= a;
        hwdata <= d;
        lat    = 0;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            lat++;
            if (hready === 1'b1)
                break;
        end
        rd = hrdata;
        e  = hresp_err;
        {hsel, htrans_valid} <= 2'b00;
        hwdata <= ~d;
    endtask
    task automatic mw(input logic p, input logic [31:0] a,
                      input logic [31:0] d, input logic xe);
        ahb(1'b1, p, 2'h2, a, d);
        `CHK(e, xe)
    endtask
    task automatic mc(input logic [31:0] a, input logic [31:0] x);
        ahb(1'b0, 1'b0, 2'h2, a, 32'h0000_0000);
        `CHK(e, 1'b0)
        `CHK(rd, x)
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        tally_and_finish;
    end
    initial begin
        {pclk, presetn, hsel, hwrite, hpriv, htrans_valid} = 6'h00;
        {psel, penable, pwrite, hsize, haddr, hwdata} = 0;
        {paddr, pwdata, n_fail, cmp_count} = 0;
        pstrb = 4'hF;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        bc(`RWGDA_OFF_CTRL, 32'h0000_0000);
        bc(`RWGDA_OFF_MAP0, 32'h0000_0000);
        `CHK(irq, 1'b0)
        $display("reset test done");
        mw(1'b0, RM + 32'h10, 32'h1234_5678, 1'b0);
        // Request edge plus the answer edge: no wait state
        `CHK(lat, 2)
        ahb(1'b1, 1'b0, 2'h0, RM + 32'h11, 32'h0000_AB00);
        ahb(1'b1, 1'b0, 2'h1, RM + 32'h12, 32'hCAFE_0000);
        mc(RM + 32'h10, 32'hCAFE_AB78);
        mw(1'b0, RM + 32'h2FFC, 32'h0BAD_F00D, 1'b0);
        mc(RM + 32'h2FFC, 32'h0BAD_F00D);
        mw(1'b0, RM + 32'h3000, 32'h0000_0001, 1'b1);
        $display("ram test done");
        apb(1'b1, `RWGDA_OFF_MAP0, 32'h0000_0002);
        apb(1'b1, 12'h004, 32'h0000_0001);
        mw(1'b1, RM + 32'h20, 32'h1111_1111, 1'b0);
        mw(1'b0, RM + 32'h20, 32'h2222_2222, 1'b1);
        mc(RM + 32'h20, 32'h1111_1111);
        mw(1'b0, RM + 32'h1C, 32'h3333_3333, 1'b0);
        mw(1'b0, RM + 32'h40, 32'h4444_4444, 1'b0);
        mw(1'b0, RM + 32'h3E0, 32'h5555_5555, 1'b0);
        mw(1'b0, RM + 32'h400, 32'h6666_6666, 1'b1);
        al = '{32'h2200_0000, 32'h23FF_FFFC, 32'h4200_0000, 32'h43FF_FFFC};
        foreach (al[i]) begin
            ahb(1'b0, 1'b1, 2'h2, al[i], 32'h0000_0000);
            `CHK(e, 1'b1)
        end
        $display("protection test done");
        apb(1'b1, `RWGDA_OFF_CTRL, 32'h0000_0002);
        mc(RM + 32'h1C, 32'h3333_3333);
        // Two wait states added to the zero-wait count
        `CHK(lat, 4)
        apb(1'b0, 12'h100, 32'h0000_0000);
        `CHK(e, 1'b1)
        paddr <= 32'h4000_1000;
        apb(1'b1, `RWGDA_OFF_CTRL, 32'h0000_0000);
        $display("wait state test done");
        u_dma.issue(1, 1'b1, RM + 32'h28, 32'h7777_7777, dmar);
        mc(RM + 32'h28, 32'h7777_7777);
        bc(`RWGDA_OFF_STAT, 32'h0000_0000);
        fork
            u_dma.issue(2, 1'b0, RM + 32'h10, 32'h0, dmar);
            u_dma.issue(1, 1'b1, RM + 32'h104, 32'h9999_9999, rd);
            u_dma.issue(0, 1'b1, RM + 32'h100, 32'h8888_8888, rd);
        join
        `CHK(dmar, 32'hCAFE_AB78)
        `CHK(u_dma.gnt_log[1], 0)
        `CHK(u_dma.gnt_log[2], 1)
        `CHK(u_dma.gnt_log[3], 2)
        `CHK(u_dma.multi, 0)
        mc(RM + 32'h104, 32'h9999_9999);
        $display("arbiter test done");
        apb(1'b1, `RWGDA_OFF_CTRL, 32'h0000_0001);
        apb(1'b1, `RWGDA_OFF_MASK, 32'h0000_0001);
        u_dma.issue(1, 1'b1, RM + 32'h30, 32'hDEAD_0000, dmar);
        bc(`RWGDA_OFF_STAT, 32'h0000_0001);
        `CHK(irq, 1'b1)
        bc(`RWGDA_OFF_FADDR, RM + 32'h30);
        bc(`RWGDA_OFF_FID, {29'h0, `RWGDA_ID_RX});
        apb(1'b1, `RWGDA_OFF_STAT, 32'h0000_0001);
        `CHK(irq, 1'b0)
        u_dma.issue(2, 1'b0, RM + 32'h20, 32'h0, dmar);
        `CHK(dmar, 32'h1111_1111)
        bc(`RWGDA_OFF_STAT, 32'h0000_0000);
        u_dma.issue(0, 1'b1, RM + 32'h24, 32'hBEEF_0000, dmar);
        bc(`RWGDA_OFF_FID, {29'h0, `RWGDA_ID_MAC});
        apb(1'b1, `RWGDA_OFF_MASK, 32'h0000_0000);
        `CHK(irq, 1'b0)
        $display("dma protection test done");
        apb(1'b1, `RWGDA_OFF_CTRL, 32'h0000_0004);
        ahb(1'b0, 1'b1, 2'h2, 32'h2200_0010, 32'h0000_0000);
        `CHK(e, 1'b1)
        bc(`RWGDA_OFF_STAT, 32'h0000_0003);
        bc(`RWGDA_OFF_MPUADR, 32'h2200_0010);
        bc(`RWGDA_OFF_MPUTYP, 32'h0000_0002);
        apb(1'b1, `RWGDA_OFF_MPUCFG, 32'h0000_003F);
        bc(`RWGDA_OFF_MPUCFG, 32'h0000_003F);
        $display("fault record test done");
        tally_and_finish;
    end
endmodule
